// file: hw/rrx_exec.sv
// execution unit for no-op, returns and rotate-left-through-carry
`timescale 1ns/100ps
`include "rrx_map.svh"
module rrx_exec (
  input  wire logic                   clk,         // 100 MHz core clock
  input  wire logic                   sys_rst,     // sync reset, high
  input  wire logic                   instValid,   // instruction offered
  input  wire logic [2:0]             instOp,      // rrx_op_t code
  input  wire logic [`RRX_DATA_W-1:0] instLiteral, // immediate operand
  input  wire logic [`RRX_ADDR_W-1:0] instAddr,    // memory operand addr
  input  wire logic                   instDest,    // destination select
  input  wire logic [`RRX_DATA_W-1:0] memRdata,    // operand byte
  input  wire logic [`RRX_PC_W-1:0]   pushPc,      // return addr to push
  input  wire logic                   pushValid,   // call pushes (1 cycle)
  input  wire logic                   gieClear,    // interrupt entry clear
  output logic                        instReady,   // ready for next op
  output logic      [`RRX_PC_W-1:0]   pc,          // program counter
  output logic      [`RRX_DATA_W-1:0] accumulator, // accumulator
  output logic                        carry,       // carry flag
  output logic                        global_interrupt_enable, // gie
  output logic      [`RRX_SP_W-1:0]   stackLevel,  // stack depth
  output logic                        memWe,       // memory write pulse
  output logic      [`RRX_ADDR_W-1:0] memWaddr,    // write address
  output logic      [`RRX_DATA_W-1:0] memWdata     // write data
);
  // ==========================================================
  // state
  // ==========================================================
  rrx_pkg::rrx_state_t state;                  // sequencer state
  rrx_pkg::rrx_state_t next_state;             // next sequencer state
  rrx_pkg::rrx_op_t    heldOp;                 // return being finished
  logic [`RRX_DATA_W-1:0] heldLit;             // literal kept for cycle 2
  logic [`RRX_PC_W-1:0] stackMem [`RRX_STACK_D]; // return stack entries

  // ==========================================================
  // decode
  // ==========================================================
  rrx_pkg::rrx_op_t opIn;                      // typed opcode
  assign opIn = rrx_pkg::rrx_op_t'(instOp);
  wire take      = instValid && (state == rrx_pkg::ST_FETCH);
  wire isNop     = take && (opIn == rrx_pkg::OP_NOP);
  wire isRot     = take && (opIn == rrx_pkg::OP_ROTL);
  wire isRetAny  = take && (opIn == rrx_pkg::OP_RET ||
                            opIn == rrx_pkg::OP_RETLIT ||
                            opIn == rrx_pkg::OP_RETINT);
  wire finishing = (state == rrx_pkg::ST_SECOND);
  wire popNow    = finishing && (stackLevel != `RRX_SP_RST);
  // top entry lives at index level-1
  wire [`RRX_SP_W-1:0] topIdx = stackLevel - 4'h1;
  wire [`RRX_PC_W-1:0] topPc  = stackMem[topIdx[2:0]];
  // full stack never wraps; push ignored to keep level honest
  wire pushOk = pushValid && !finishing &&
                (stackLevel != 4'(`RRX_STACK_D));

  // ==========================================================
  // rotate datapath
  // ==========================================================
  logic [`RRX_DATA_W-1:0] rotRes;              // rotated byte
  logic                   rotCarry;            // new carry
  rrx_rotate uRot (
    .operand  (memRdata),
    .carryIn  (carry),
    .result   (rotRes),
    .carryOut (rotCarry)
  );
  wire rotToAcc = isRot && (instDest == `RRX_DEST_ACC);
  wire rotToMem = isRot && (instDest == `RRX_DEST_MEM);

  // ==========================================================
  // sequencer
  // ==========================================================
  // returns take a second cycle
  always_comb
  begin
    next_state = state;
    case (state)
      rrx_pkg::ST_FETCH:
        if (isRetAny)
          next_state = rrx_pkg::ST_SECOND;
      rrx_pkg::ST_SECOND:
        next_state = rrx_pkg::ST_FETCH;
      default:
        next_state = rrx_pkg::ST_FETCH;
    endcase
  end

  // state and captured return info
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state   <= rrx_pkg::ST_FETCH;
      heldOp  <= rrx_pkg::OP_NOP;
      heldLit <= `RRX_ACC_RST;
    end
    else
    begin
      state <= next_state;
      if (isRetAny)
      begin
        heldOp  <= opIn;
        heldLit <= instLiteral;
      end
    end
  end

  // ready low during the second return cycle
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      instReady <= 1'b1;
    else
      instReady <= (next_state == rrx_pkg::ST_FETCH);
  end

  // ==========================================================
  // program counter
  // ==========================================================
  // nop and rotate step pc by one
  wire stepPc = isNop || isRot;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      pc <= `RRX_PC_RST;
    else if (finishing)
      pc <= topPc;
    else if (stepPc)
      pc <= pc + 10'h001;
  end

  // ==========================================================
  // return stack
  // ==========================================================
  // storage written only on a push, one entry per slot
  genvar gi;
  generate
    for (gi = 0; gi < `RRX_STACK_D; gi++)
    begin : gSlot
      always_ff @(posedge clk)
      begin
        if (pushOk && stackLevel[2:0] == 3'(gi))
          stackMem[gi] <= pushPc;
      end
    end
  endgenerate

  // level: pop on return finish, push on call
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      stackLevel <= `RRX_SP_RST;
    else if (popNow)
      stackLevel <= stackLevel - 4'h1;
    else if (pushOk)
      stackLevel <= stackLevel + 4'h1;
  end

  // ==========================================================
  // interrupt enable
  // ==========================================================
  // set on interrupt and literal returns
  wire gieSet = finishing && (heldOp == rrx_pkg::OP_RETINT ||
                              heldOp == rrx_pkg::OP_RETLIT);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      global_interrupt_enable <= 1'b0;
    else if (gieSet)
      // set wins over an entry clear in the same cycle
      global_interrupt_enable <= 1'b1;
    else if (gieClear)
      global_interrupt_enable <= 1'b0;
  end

  // ==========================================================
  // accumulator and carry
  // ==========================================================
  // literal written when return completes
  wire accLit = finishing && (heldOp == rrx_pkg::OP_RETLIT);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      accumulator <= `RRX_ACC_RST;
    else if (accLit)
      accumulator <= heldLit;
    else if (rotToAcc)
      accumulator <= rotRes;
  end

  // carry touched only by rotate
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      carry <= 1'b0;
    else if (isRot)
      carry <= rotCarry;
  end

  // ==========================================================
  // memory write-back
  // ==========================================================
  // write back to source location
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      memWe    <= 1'b0;
      memWaddr <= {`RRX_ADDR_W{1'b0}};
      memWdata <= `RRX_ACC_RST;
    end
    else
    begin
      memWe <= rotToMem;
      if (rotToMem)
      begin
        memWaddr <= instAddr;
        memWdata <= rotRes;
      end
    end
  end
endmodule

// file: hw/rrx_map.svh
// constants for the return and rotate execution block
`ifndef RRX_MAP_SVH
`define RRX_MAP_SVH
`define RRX_PC_W       10
`define RRX_DATA_W     8
`define RRX_ADDR_W     6
`define RRX_SP_W       4
`define RRX_STACK_D    8
`define RRX_PC_RST     10'h000
`define RRX_ACC_RST    8'h00
`define RRX_SP_RST     4'h0
`define RRX_DEST_ACC   1'b0
`define RRX_DEST_MEM   1'b1
`endif

// file: hw/rrx_pkg.sv
// types for the return and rotate execution block
package rrx_pkg;
  // operation selector presented with each instruction
  typedef enum logic [2:0] {
    OP_NOP    = 3'b000,
    OP_RET    = 3'b001,
    OP_RETLIT = 3'b010,
    OP_RETINT = 3'b011,
    OP_ROTL   = 3'b100
  } rrx_op_t;
  // execution sequencer state
  typedef enum logic [0:0] {
    ST_FETCH  = 1'b0,
    ST_SECOND = 1'b1
  } rrx_state_t;
endpackage

// file: hw/rrx_rotate.sv
// rotate-left-through-carry datapath
`timescale 1ns/100ps
`include "rrx_map.svh"
module rrx_rotate (
  input  wire logic [`RRX_DATA_W-1:0] operand,   // source byte
  input  wire logic                   carryIn,   // old carry
  output logic      [`RRX_DATA_W-1:0] result,    // rotated byte
  output logic                        carryOut   // new carry
);
  // msb leaves into carry, old carry enters at lsb
  assign result   = {operand[`RRX_DATA_W-2:0], carryIn};
  assign carryOut = operand[`RRX_DATA_W-1];
endmodule

// file: verif/rrx_exec_sva.sv
// checker for the return and rotate execution block
`timescale 1ns/100ps
module rrx_exec_sva (
  input wire logic       clk,         // core clock
  input wire logic       sys_rst,     // sync reset
  input wire logic       instValid,   // offered
  input wire logic [2:0] instOp,      // op code
  input wire logic [7:0] instLiteral, // immediate
  input wire logic [5:0] instAddr,    // operand addr
  input wire logic       instDest,    // dest select
  input wire logic [7:0] memRdata,    // operand byte
  input wire logic       instReady,   // ready
  input wire logic [9:0] pc,          // program counter
  input wire logic [7:0] accumulator, // accumulator
  input wire logic       carry,       // carry flag
  input wire logic       global_interrupt_enable, // int enable
  input wire logic [3:0] stackLevel,  // stack depth
  input wire logic       memWe,       // write pulse
  input wire logic [5:0] memWaddr,    // write addr
  input wire logic [7:0] memWdata     // write data
);
  // ==========
  // decode of taken ops
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire tk    = instValid && instReady;                  // take edge
  wire isPop = tk && instOp inside {3'h1, 3'h2, 3'h3}; // any return
  // ==========
  // properties
  property p_nop;
    tk && instOp == 3'h0 |=> pc == $past(pc) + 10'h1
      && accumulator == $past(accumulator) && !memWe;
  endproperty
  a_nop: assert property (p_nop) else $error("nop side effect");
  property p_lit;
    tk && instOp == 3'h2 |-> ##2 accumulator == $past(instLiteral, 2);
  endproperty
  a_lit: assert property (p_lit) else $error("literal lost");
  property p_ie;
    tk && instOp inside {3'h2, 3'h3} |-> ##2 global_interrupt_enable;
  endproperty
  a_ie: assert property (p_ie) else $error("enable not set");
  property p_pop;
    isPop && stackLevel != 4'h0 |-> ##2
      stackLevel == $past(stackLevel, 2) - 4'h1;
  endproperty
  a_pop: assert property (p_pop) else $error("level not popped");
  property p_keep;
    tk && instOp == 3'h1 |-> ##2 carry == $past(carry, 2)
      && global_interrupt_enable == $past(global_interrupt_enable, 2);
  endproperty
  a_keep: assert property (p_keep) else $error("flags moved");
  property p_mem;
    tk && instOp == 3'h4 && instDest |=> memWe
      && memWdata == {$past(memRdata[6:0]), $past(carry)}
      && memWaddr == $past(instAddr) && carry == $past(memRdata[7]);
  endproperty
  a_mem: assert property (p_mem) else $error("bad write");
  property p_acc;
    tk && instOp == 3'h4 && !instDest |=> !memWe
      && accumulator == {$past(memRdata[6:0]), $past(carry)};
  endproperty
  a_acc: assert property (p_acc) else $error("bad rotate");
  property p_two;
    isPop |=> !instReady ##1 instReady;
  endproperty
  a_two: assert property (p_two) else $error("return length");
endmodule
bind rrx_exec rrx_exec_sva u_sva (.clk, .sys_rst, .instValid, .instOp,
  .instLiteral, .instAddr, .instDest, .memRdata, .instReady, .pc,
  .accumulator, .carry, .global_interrupt_enable, .stackLevel, .memWe,
  .memWaddr, .memWdata);

// file: verif/rrx_exec_bench.sv
// self-checking bench for the return and rotate execution block
`timescale 1ns/100ps
module rrx_exec_bench;
  // ==========
  // stimulus, outputs, shadow state
  logic        clk = 1'b0, sys_rst = 1'b1;          // clock, reset
  logic        instValid = 1'b0, instDest = 1'b0;   // request
  logic [2:0]  instOp = 3'h0;                       // op code
  logic [7:0]  instLiteral = 8'h00, memRdata = 8'h00; // data in
  logic [5:0]  instAddr = 6'h00;                    // operand addr
  logic [9:0]  pushPc = 10'h000;                    // call address
  logic        pushValid = 1'b0, gieClear = 1'b0;   // side events
  wire         instReady, carry, intEn, memWe;      // flags out
  wire  [9:0]  pc;                                  // program counter
  wire  [7:0]  accum, memWdata;                     // data out
  wire  [3:0]  stackLevel;                          // depth
  wire  [5:0]  memWaddr;                            // write addr
  logic [9:0]  mPc = 10'h000, mStk [8];             // model pc, stack
  logic [7:0]  mAcc = 8'h00, mWd = 8'h00, res;      // model data
  logic [5:0]  mWa = 6'h00;                         // model addr
  logic [3:0]  mLvl = 4'h0;                         // model depth
  logic        mC = 1'b0, mIe = 1'b0, mWe, pend = 1'b0; // model flags
  logic [38:0] expQ [$];                            // expected results
  logic [31:0] r;                                   // random word
  integer      seed = 32'h7319, nFail = 0, checked = 0, i; // counters
  rrx_exec u_dut (.clk, .sys_rst, .instValid, .instOp, .instLiteral,
    .instAddr, .instDest, .memRdata, .pushPc, .pushValid, .gieClear,
    .instReady, .pc, .accumulator(accum), .carry,
    .global_interrupt_enable(intEn), .stackLevel, .memWe, .memWaddr,
    .memWdata);
  always #5 clk = ~clk;
  // ==========
  // tasks
  task automatic check(input logic [38:0] seen, exp);
    checked++;
    if (seen !== exp)
    begin
      nFail++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, nFail);
    if (nFail == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // one side event of a push, an enable clear or both together; idles two cycles so a return is over first
  task automatic side(input logic pv, gc, input logic [9:0] v);
    instValid <= 1'b0;
    repeat (2) @(posedge clk);
    pushValid <= pv;
    gieClear <= gc;
    pushPc <= v;
    @(posedge clk);
    pushValid <= 1'b0;
    gieClear <= 1'b0;
    if (pv && mLvl < 4'h8)
    begin
      mStk[mLvl[2:0]] = v;
      mLvl = mLvl + 4'h1;
    end
    if (gc)
      mIe = 1'b0;
  endtask
  task automatic run(input logic [2:0] o, input logic [7:0] lit, rd,
                     input logic d, input logic [5:0] a);
    instValid <= 1'b1;
    instOp <= o;
    instLiteral <= lit;
    memRdata <= rd;
    instDest <= d;
    instAddr <= a;
    mWe = 1'b0;
    if (o inside {3'h1, 3'h2, 3'h3})
    begin
      mPc = mStk[3'(mLvl - 4'h1)];
      mLvl = (mLvl == 4'h0) ? mLvl : mLvl - 4'h1;
      mAcc = (o == 3'h2) ? lit : mAcc;
      mIe = (o == 3'h1) ? mIe : 1'b1;
    end
    else if (o == 3'h4)
    begin
      {mC, res} = {rd, mC};
      mWe = d;
      mWa = d ? a : mWa;
      mWd = d ? res : mWd;
      mAcc = d ? mAcc : res;
      mPc = mPc + 10'h1;
    end
    else if (o == 3'h0)
      mPc = mPc + 10'h1;
    expQ.push_back({mPc, mAcc, mC, mIe, mLvl, mWe, mWa, mWd});
    do @(posedge clk); while (!instReady);
  endtask
  // ==========
  // result watcher: compares once the instruction has completed
  always @(negedge clk)
  begin
    if (pend && instReady)
    begin
      check({pc, accum, carry, intEn, stackLevel, memWe, memWaddr,
             memWdata}, expQ.pop_front());
      pend = 1'b0;
    end
    if (instValid && instReady && !sys_rst)
      pend = 1'b1;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    // fill past depth, then pop past empty
    for (i = 0; i < 9; i++)
      side(1'b1, 1'b0, 10'(i * 37 + 1));
    for (i = 0; i < 10; i++)
      run(3'h1, 8'h00, 8'h00, 1'b0, 6'h00);
    $display("stack test done");
    run(3'h0, 8'h00, 8'h00, 1'b0, 6'h00);
    run(3'h4, 8'h00, 8'ha5, 1'b1, 6'h11);
    run(3'h2, 8'h55, 8'h00, 1'b0, 6'h00);
    run(3'h3, 8'h00, 8'h00, 1'b0, 6'h00);
    $display("directed test done");
    for (i = 0; i < 300; i++)
    begin
      r = $random(seed);
      if (r[4:3] == 2'h0)
        side(r[5], r[6], r[17:8]);
      run(r[2:0], r[15:8], r[23:16], r[24], r[30:25]);
    end
    $display("random test done");
    instValid <= 1'b0;
    repeat (4) @(posedge clk);
    tally_and_finish;
  end
  // hang guard, far beyond the expected run length
  initial
  begin
    repeat (5000) @(posedge clk);
    nFail++;
    tally_and_finish;
  end
endmodule
